// ==== design/scp_serial_port.sv ====
/*
  Four-wire serial control port with the dac latches, the configuration
  registers and the open-drain interrupt pin.
  Assumes the host clock, data and select arrive asynchronously and are
  slow against clk; comparator events and converter data come from logic
  on clk.
*/
// Notes on behaviour
// - bytes travel msb first, sampled on clock
// - reply bits shift out on host clock
// - reply pin released unless returning data
// - select low starts, high ends or aborts
// - pending interrupt pulls the request low
// - interrupt pin is open drain
// - flags record events; only enabled ones interrupt
// - dacs default to narrow, one byte
// - wide dacs take two data bytes
// - command then data latches the dac code
// - disabled dac output left undriven
// - dac code is unsigned, n bits wide
// - everything configured only through serial port
// - conversion clock from programmable divider
// - two attenuators set independently
// - one command byte, then none, one or two
// - second dac byte only when wide
`timescale 1ns/1ps
module scp_serial_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sclk_pin,
  input wire logic cmd_pin,
  input wire logic cs_n_pin,
  output logic reply_data,
  output logic reply_oe_n,
  output logic irq_data,
  output logic irq_oe_n,
  input wire logic [scp_pkg::SCP_NUM_IRQ-1:0] irq_events,
  input wire scp_pkg::scp_adc_t adc_data,
  output scp_pkg::scp_cfg_s cfg,
  output scp_pkg::scp_dac_t dac_code,
  output logic [scp_pkg::SCP_NUM_DAC-1:0] dac_wide_select,
  output logic [scp_pkg::SCP_NUM_DAC-1:0] dac_drive_en,
  output scp_pkg::scp_level_t level_upper,
  output scp_pkg::scp_level_t level_lower,
  output logic adc_tick
);
  import scp_pkg::*;

  scp_state_s st, next_st;
  logic rise, fall, byte_last;
  logic [SCP_BYTE_W-1:0] rx_byte;
  logic [SCP_NUM_IRQ-1:0] irq_en, next_irq_en, flag_clr;
  logic [SCP_BYTE_W-1:0] w1, w2;
  logic [1:0] idx;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  function automatic logic is_dac(input logic [7:0] c);
    return c >= SCP_CMD_DAC1 && c <= SCP_CMD_DAC3;
  endfunction : is_dac

  function automatic logic is_level(input logic [7:0] c);
    return c[7:2] == SCP_CMD_LEVEL1[7:2];
  endfunction : is_level

  function automatic logic is_read(input logic [7:0] c);
    return c == SCP_CMD_IRQRD || c[7:2] == SCP_CMD_ADCRD1[7:2];
  endfunction : is_read

  // data bytes that follow a command; unknown codes take none
  function automatic logic [1:0] need_bytes(input logic [7:0] c,
                                            input logic [7:0] ctrl);
    logic [1:0] i;
    i = 2'(c - SCP_CMD_DAC1);
    if (is_dac(c)) begin
      return ctrl[SCP_WIDE_TOP-i] ? SCP_LEN_TWO : SCP_LEN_ONE;
    end else if (c == SCP_CMD_CLKCTL || c == SCP_CMD_DACCTL ||
                 c == SCP_CMD_ADCCTL || c == SCP_CMD_IRQRD) begin
      return SCP_LEN_ONE;
    end else if (c == SCP_CMD_ATTEN || is_level(c) ||
                 c[7:2] == SCP_CMD_ADCRD1[7:2]) begin
      return SCP_LEN_TWO;
    end
    return SCP_LEN_NONE;
  endfunction : need_bytes

  // edges of the synchronised host clock; the first stage only feeds the second
  assign rise = st.sclk_s2 & ~st.sclk_prev;
  assign fall = ~st.sclk_s2 & st.sclk_prev;
  assign byte_last = st.bit_cnt == SCP_BIT_LAST;
  assign rx_byte = {st.rx[SCP_BYTE_W-2:0], st.mosi_s2};

  // ---------------------------------------------------------------------
  // interrupt enables: a zero reference level disables its flag
  // ---------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SCP_NUM_ADC; g++) begin : g_irq_en
      assign irq_en[2*g] = |st.level_lower[g];
      assign irq_en[2*g+1] = |st.level_upper[g];
      assign next_irq_en[2*g] = |next_st.level_lower[g];
      assign next_irq_en[2*g+1] = |next_st.level_upper[g];
    end
    for (g = 0; g < SCP_NUM_DAC; g++) begin : g_dac_bits
      assign dac_wide_select[g] = st.cfg.dac_ctrl[SCP_WIDE_TOP-g];
      // low drive enable leaves the channel open circuit
      assign dac_drive_en[g] = st.cfg.dac_ctrl[SCP_EN_TOP-g];
    end
  endgenerate

  // write data of the current byte: two-byte writes use the held first
  assign w1 = st.byte_idx ? st.hold : rx_byte;
  assign w2 = rx_byte;
  assign idx = st.cmd[1:0];

  // ---------------------------------------------------------------------
  // transfer sequencer and register writes
  // ---------------------------------------------------------------------
  always_comb begin
    next_st = st;
    flag_clr = '0;
    next_st.sclk_s1 = sclk_pin;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_prev = st.sclk_s2;
    next_st.mosi_s1 = cmd_pin;
    next_st.mosi_s2 = st.mosi_s1;
    next_st.cs_s1 = cs_n_pin;
    next_st.cs_s2 = st.cs_s1;
    if (st.cs_s2) begin
      // select high ends or aborts; partial bytes are simply dropped
      next_st.phase = SCP_PH_IDLE;
      next_st.bit_cnt = '0;
      next_st.byte_idx = 1'b0;
      next_st.reply_oe_n = 1'b1;
    end else begin
      case (st.phase)
        SCP_PH_IDLE: begin
          next_st.phase = SCP_PH_CMD;
        end
        SCP_PH_CMD: begin
          if (rise) begin
            next_st.rx = rx_byte;
            next_st.bit_cnt = st.bit_cnt + 1'b1;
            if (byte_last) begin
              next_st.cmd = rx_byte;
              next_st.nbytes = need_bytes(rx_byte, st.cfg.dac_ctrl);
              next_st.byte_idx = 1'b0;
              if (rx_byte == SCP_CMD_RESET) begin
                // levels and interrupt flags are kept; config and dac codes return to default
                next_st.cfg = SCP_CFG_RST;
                next_st.dac_code = '0;
                next_st.phase = SCP_PH_DONE;
              end else if (is_read(rx_byte)) begin
                next_st.phase = SCP_PH_RDATA;
                if (rx_byte == SCP_CMD_IRQRD) begin
                  next_st.tx = st.irq_flags;
                  next_st.tx2 = '0;
                  flag_clr = st.irq_flags;
                end else begin
                  next_st.tx = adc_data[rx_byte[1:0]][SCP_BYTE_W-1:0];
                  next_st.tx2 = SCP_BYTE_W'(
                    adc_data[rx_byte[1:0]][SCP_DAC_W-1:SCP_BYTE_W]);
                end
              end else if (need_bytes(rx_byte, st.cfg.dac_ctrl) !=
                           SCP_LEN_NONE) begin
                next_st.phase = SCP_PH_WDATA;
              end else begin
                next_st.phase = SCP_PH_DONE;
              end
            end
          end
        end
        SCP_PH_WDATA: begin
          if (rise) begin
            next_st.rx = rx_byte;
            next_st.bit_cnt = st.bit_cnt + 1'b1;
            if (byte_last) begin
              next_st.hold = rx_byte;
              if (st.nbytes == SCP_LEN_ONE || st.byte_idx) begin
                next_st.phase = SCP_PH_DONE;
                // latch only once every expected byte is in
                if (st.cmd == SCP_CMD_CLKCTL) begin
                  next_st.cfg.adc_div = w1[SCP_DIV_W-1:0];
                end
                if (st.cmd == SCP_CMD_ATTEN) begin
                  next_st.cfg.attenuator_one = w1[SCP_ATT_W-1:0];
                  next_st.cfg.attenuator_two = w2[SCP_ATT_W-1:0];
                end
                if (st.cmd == SCP_CMD_DACCTL) begin
                  next_st.cfg.dac_ctrl = w1;
                end
                if (st.cmd == SCP_CMD_ADCCTL) begin
                  next_st.cfg.adc_ctrl = w1;
                end
                if (is_dac(st.cmd)) begin
                  // unsigned code; narrow mode leaves top bits zero
                  next_st.dac_code[2'(st.cmd - SCP_CMD_DAC1)] =
                    st.nbytes == SCP_LEN_TWO ?
                    {w2[SCP_DAC_W-SCP_BYTE_W-1:0], w1} :
                    SCP_DAC_W'(w1);
                end
                if (is_level(st.cmd)) begin
                  next_st.level_upper[idx] = w1;
                  next_st.level_lower[idx] = w2;
                end
              end else begin
                next_st.byte_idx = 1'b1;
              end
            end
          end
        end
        SCP_PH_RDATA: begin
          if (fall) begin
            next_st.reply = st.tx[SCP_BYTE_W-1];
            next_st.tx = {st.tx[SCP_BYTE_W-2:0], 1'b0};
            next_st.reply_oe_n = 1'b0;
          end
          if (rise) begin
            next_st.bit_cnt = st.bit_cnt + 1'b1;
            if (byte_last) begin
              if (st.nbytes == SCP_LEN_TWO && !st.byte_idx) begin
                next_st.byte_idx = 1'b1;
                next_st.tx = st.tx2;
              end else begin
                next_st.phase = SCP_PH_DONE;
                next_st.reply_oe_n = 1'b1;
              end
            end
          end
        end
        SCP_PH_DONE: begin
          next_st.phase = SCP_PH_DONE;
        end
        default: begin
          next_st.phase = SCP_PH_IDLE;
        end
      endcase
    end
    // a new event beats the clear by a flag read
    next_st.irq_flags = (st.irq_flags & ~flag_clr) | irq_events;
    next_st.irq_oe_n = ~|(next_st.irq_flags & next_irq_en);
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= scp_state_rst();
    end else if (ce) begin
      st <= next_st;
    end
  end

  // conversion clock; runs only while some input is active
  scp_clk_div #(
    .W(SCP_DIV_W)
  ) u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .enable(|st.cfg.adc_ctrl[SCP_ADC_ACT_HI:SCP_ADC_ACT_LO]),
    .ratio_code(st.cfg.adc_div),
    .tick(adc_tick)
  );

  // output data of the open-drain pin is always low; only oe moves
  assign irq_data = 1'b0;
  assign irq_oe_n = st.irq_oe_n;
  assign reply_data = st.reply;
  assign reply_oe_n = st.reply_oe_n;
  assign cfg = st.cfg;
  assign dac_code = st.dac_code;
  assign level_upper = st.level_upper;
  assign level_lower = st.level_lower;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_REPLY_RELEASED: assert property (
    ce && st.cs_s2 |=> st.reply_oe_n && st.phase == SCP_PH_IDLE)
    else $error("reply driven with select high");
  AST_IRQ_MATCH: assert property (
    st.irq_oe_n == !(|(st.irq_flags & irq_en)))
    else $error("interrupt pin disagrees with enabled flags");
  AST_IRQ_EVENT: assert property (
    ce && |(irq_events & next_irq_en) |=> !st.irq_oe_n)
    else $error("enabled event did not pull interrupt low");
  AST_RESET_NARROW: assert property (
    $past(sys_rst) |-> st.cfg.dac_ctrl == '0 && st.dac_code == '0)
    else $error("dacs not narrow after reset");
  AST_ABORT: assert property (
    ce && st.cs_s2 && st.phase == SCP_PH_WDATA
    |=> st.phase == SCP_PH_IDLE && $stable(st.dac_code))
    else $error("abort updated a latch");
  AST_CMD_BYTE: assert property (
    ce && !st.cs_s2 && rise && st.phase == SCP_PH_CMD && byte_last
    |=> st.cmd == {$past(st.rx[6:0]), $past(st.mosi_s2)})
    else $error("command byte not assembled msb first");
  AST_NARROW_ONE: assert property (
    ce && !st.cs_s2 && rise && byte_last && st.phase == SCP_PH_WDATA &&
    st.cmd == SCP_CMD_DAC1 && !st.cfg.dac_ctrl[SCP_WIDE_TOP]
    |=> st.phase == SCP_PH_DONE && st.dac_code[0][9:8] == 2'h0)
    else $error("narrow dac load took more than one byte");
  AST_REPLY_BIT: assert property (
    ce && !st.cs_s2 && fall && st.phase == SCP_PH_RDATA
    |=> !st.reply_oe_n && st.reply == $past(st.tx[7]))
    else $error("reply bit not shifted on falling clock");
  AST_RESET_CMD: assert property (
    ce && !st.cs_s2 && rise && byte_last && st.phase == SCP_PH_CMD &&
    rx_byte == SCP_CMD_RESET |=> st.phase == SCP_PH_DONE)
    else $error("reset command expected data");

  COV_DAC_WIDE: cover property (
    st.phase == SCP_PH_WDATA && st.byte_idx ##[1:200]
    st.phase == SCP_PH_DONE);
  COV_READ_TWO: cover property (
    st.phase == SCP_PH_RDATA && st.byte_idx && !st.reply_oe_n);
  COV_ABORT: cover property (
    st.phase == SCP_PH_WDATA && st.bit_cnt != '0 ##1 st.cs_s2);
  COV_IRQ: cover property ($fell(st.irq_oe_n));
endmodule : scp_serial_port

// ==== design/scp_pkg.sv ====
/*
  Shared constants and types of the serial control port: command codes,
  field positions, phase encoding and the packed state of both modules.
  Assumes a single system clock; every pin is synchronised in the top.
*/
package scp_pkg;
  // ---------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------
  localparam int SCP_BYTE_W = 8;
  localparam int SCP_DAC_W = 10;
  localparam int SCP_NUM_DAC = 3;
  localparam int SCP_NUM_ADC = 4;
  localparam int SCP_NUM_IRQ = 8;
  localparam int SCP_DIV_W = 3;
  localparam int SCP_ATT_W = 6;
  localparam logic [2:0] SCP_BIT_LAST = 3'h7;

  // ---------------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------------
  localparam logic [7:0] SCP_CMD_RESET = 8'h01;
  localparam logic [7:0] SCP_CMD_CLKCTL = 8'hD0;
  localparam logic [7:0] SCP_CMD_IRQRD = 8'hD1;
  localparam logic [7:0] SCP_CMD_ATTEN = 8'hD2;
  localparam logic [7:0] SCP_CMD_DACCTL = 8'hD3;
  localparam logic [7:0] SCP_CMD_DAC1 = 8'hD4;
  localparam logic [7:0] SCP_CMD_DAC3 = 8'hD6;
  localparam logic [7:0] SCP_CMD_ADCCTL = 8'hD7;
  localparam logic [7:0] SCP_CMD_LEVEL1 = 8'hD8;
  localparam logic [7:0] SCP_CMD_ADCRD1 = 8'hDC;
  localparam logic [1:0] SCP_LEN_NONE = 2'h0;
  localparam logic [1:0] SCP_LEN_ONE = 2'h1;
  localparam logic [1:0] SCP_LEN_TWO = 2'h2;

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int SCP_WIDE_TOP = 7;   // dac n wide select at bit 7-n
  localparam int SCP_EN_TOP = 3;     // dac n enable at bit 3-n
  localparam int SCP_ADC_ACT_LO = 1; // active inputs at bits 4..1
  localparam int SCP_ADC_ACT_HI = 4;

  // ---------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------
  typedef enum logic [4:0] {
    SCP_PH_IDLE  = 5'b00001,
    SCP_PH_CMD   = 5'b00010,
    SCP_PH_WDATA = 5'b00100,
    SCP_PH_RDATA = 5'b01000,
    SCP_PH_DONE  = 5'b10000
  } scp_phase_e;

  typedef logic [SCP_NUM_DAC-1:0][SCP_DAC_W-1:0] scp_dac_t;
  typedef logic [SCP_NUM_ADC-1:0][SCP_DAC_W-1:0] scp_adc_t;
  typedef logic [SCP_NUM_ADC-1:0][SCP_BYTE_W-1:0] scp_level_t;

  typedef struct packed {
    logic [SCP_DIV_W-1:0] adc_div;
    logic [SCP_ATT_W-1:0] attenuator_one;
    logic [SCP_ATT_W-1:0] attenuator_two;
    logic [SCP_BYTE_W-1:0] dac_ctrl;
    logic [SCP_BYTE_W-1:0] adc_ctrl;
  } scp_cfg_s;

  typedef struct packed {
    logic sclk_s1, sclk_s2, sclk_prev;
    logic mosi_s1, mosi_s2;
    logic cs_s1, cs_s2;
    scp_phase_e phase;
    logic [2:0] bit_cnt;
    logic byte_idx;
    logic [1:0] nbytes;
    logic [SCP_BYTE_W-1:0] rx, cmd, hold, tx, tx2;
    logic reply, reply_oe_n, irq_oe_n;
    scp_cfg_s cfg;
    scp_dac_t dac_code;
    scp_level_t level_upper, level_lower;
    logic [SCP_NUM_IRQ-1:0] irq_flags;
  } scp_state_s;

  typedef struct packed {
    logic [SCP_DIV_W-1:0] cnt;
    logic tick;
  } scp_div_s;

  localparam scp_cfg_s SCP_CFG_RST = '0;

  // reset image of the port: select idle high, pins released
  function automatic scp_state_s scp_state_rst();
    scp_state_s s;
    s = '0;
    s.sclk_s1 = 1'b1;
    s.sclk_s2 = 1'b1;
    s.sclk_prev = 1'b1;
    s.cs_s1 = 1'b1;
    s.cs_s2 = 1'b1;
    s.phase = SCP_PH_IDLE;
    s.reply_oe_n = 1'b1;
    s.irq_oe_n = 1'b1;
    return s;
  endfunction : scp_state_rst
endpackage : scp_pkg

// ==== design/scp_clk_div.sv ====
/*
  Programmable divider that makes the conversion clock enable from the
  system clock, which stands for the crystal or external clock input.
  Assumes ratio_code changes only while the converter is idle.
*/
`timescale 1ns/1ps
module scp_clk_div #(
  parameter int W = scp_pkg::SCP_DIV_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [W-1:0] ratio_code,
  output logic tick
);
  import scp_pkg::*;

  scp_div_s st, next_st;

  // ---------------------------------------------------------------------
  // divide by ratio_code + 1
  // ---------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!enable) begin
      next_st.cnt = '0;
    end else if (st.cnt >= ratio_code) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_DIV_SPACING: assert property (
    ce && st.tick && ratio_code != '0 && $stable(ratio_code) |=> !st.tick)
    else $error("conversion tick repeated too soon");
endmodule : scp_clk_div

// ==== tb/scp_host_model.sv ====
/*
  Host side of the four-wire serial port: makes the serial clock, the
  command bit and the select, and samples the reply line.
  Assumes the bench resolves the tri-state reply line before it arrives.
*/
`timescale 1ns/1ps
module scp_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cmd,
  output logic cs_n,
  input wire logic reply
);
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  // each serial clock phase lasts 5 clk, two more than the port's minimum
  localparam int HALF = 5;

  initial begin
    sclk = 1'b1;
    cmd = 1'b1;
    cs_n = 1'b1;
  end

  // all pin changes land just after a clk edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_clk

  // select change, with a quiet serial clock on both sides of it
  task automatic sel(input logic lvl);
    wait_clk(HALF);
    cs_n = lvl;
    wait_clk(HALF);
  endtask : sel

  // ---------------------------------------------------------------------
  // byte shifter
  // ---------------------------------------------------------------------
  // nb bits msb first; data changes on the fall, reply taken at the rise
  task automatic shift(input logic [7:0] b, input int nb,
                       output logic [7:0] r);
    r = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      sclk = 1'b0;
      cmd = b[i];
      wait_clk(HALF);
      r[i] = reply;
      sclk = 1'b1;
      wait_clk(HALF);
    end
    cmd = ~cmd; // a released line must not keep showing the last bit
  endtask : shift
endmodule : scp_host_model

// ==== tb/tb_top.sv ====
/*
  Self-checking bench of the serial control port: table of register
  writes and reads, then divider, reset, abort, dac width and interrupt cases.
  Assumes the host model above and the assertions inside the design.
*/
`timescale 1ns/1ps
module tb_top;
  import scp_pkg::*;
  // ---------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------
  logic clk, sys_rst, ce, sclk, cmd, cs_n;
  logic reply_data, reply_oe_n, irq_data, irq_oe_n, adc_tick, reply_line;
  logic reply_hold = 1'b0;
  logic [SCP_NUM_IRQ-1:0] irq_events;
  scp_adc_t adc_data;
  scp_cfg_s cfg;
  scp_dac_t dac_code;
  logic [SCP_NUM_DAC-1:0] dac_wide_select, dac_drive_en;
  scp_level_t level_upper, level_lower;
  int fail_count = 0;
  int cmp_count = 0;
  logic [15:0] rd;
  int ticks;

  typedef struct packed {
    logic [7:0] c;
    logic [1:0] nw;
    logic [15:0] wd;
    logic [1:0] nr;
    logic [15:0] ex;
  } scp_tb_row_s;

  // released reply line shows the inverse of its last driven level
  assign reply_line = (reply_oe_n === 1'b0) ? reply_data : ~reply_hold;
  always @(posedge clk) begin
    if (reply_oe_n === 1'b0) begin
      reply_hold <= reply_data;
    end
  end

  scp_host_model host (.clk(clk), .sclk(sclk), .cmd(cmd), .cs_n(cs_n),
    .reply(reply_line));

  scp_serial_port DUT (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .sclk_pin(sclk), .cmd_pin(cmd), .cs_n_pin(cs_n),
    .reply_data(reply_data), .reply_oe_n(reply_oe_n),
    .irq_data(irq_data), .irq_oe_n(irq_oe_n), .irq_events(irq_events),
    .adc_data(adc_data), .cfg(cfg), .dac_code(dac_code),
    .dac_wide_select(dac_wide_select), .dac_drive_en(dac_drive_en),
    .level_upper(level_upper), .level_lower(level_lower),
    .adc_tick(adc_tick));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // the output field that a write command lands in
  function automatic logic [15:0] look(input logic [7:0] c);
    case (c)
      SCP_CMD_CLKCTL: look = {13'h0000, cfg.adc_div};
      SCP_CMD_ATTEN: look = {4'h0, cfg.attenuator_one, cfg.attenuator_two};
      SCP_CMD_DACCTL: look = {8'h00, cfg.dac_ctrl};
      SCP_CMD_ADCCTL: look = {8'h00, cfg.adc_ctrl};
      8'hD4, 8'hD5, 8'hD6: look = {6'h00, dac_code[c[1:0]]};
      default: look = {level_upper[c[1:0]], level_lower[c[1:0]]};
    endcase
  endfunction : look

  // one whole transaction under one select
  task automatic xact(input logic [7:0] c, input int nw,
                      input logic [15:0] wd, input int nr,
                      output logic [15:0] r);
    logic [7:0] b;
    r = 16'h0000;
    host.sel(1'b0);
    host.shift(c, 8, b);
    if (nw > 0) host.shift(wd[15:8], 8, b);
    if (nw > 1) host.shift(wd[7:0], 8, b);
    if (nr > 0) begin
      host.shift(8'h3C, 8, b);
      r[15:8] = b;
    end
    if (nr > 1) begin
      host.shift(8'hC3, 8, b);
      r[7:0] = b;
    end
    host.sel(1'b1);
    chk({15'h0000, reply_oe_n}, 16'h0001);
  endtask : xact

  // single-cycle event pulse on the comparator inputs
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    #1 irq_events = e;
    @(posedge clk);
    #1 irq_events = 8'h00;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse

  // ---------------------------------------------------------------------
  // ordinary cases
  // ---------------------------------------------------------------------
  scp_tb_row_s rows [11] = '{
    '{8'hD4, 2'h1, 16'hA500, 2'h0, 16'h00A5},
    '{8'hD3, 2'h1, 16'h4E00, 2'h0, 16'h004E},
    '{8'hD5, 2'h2, 16'h5A03, 2'h0, 16'h035A},
    '{8'hD6, 2'h1, 16'hFF00, 2'h0, 16'h00FF},
    '{8'hD2, 2'h2, 16'h152A, 2'h0, 16'h056A},
    '{8'hD0, 2'h1, 16'h0300, 2'h0, 16'h0003},
    '{8'hD8, 2'h2, 16'h8010, 2'h0, 16'h8010},
    '{8'hDB, 2'h2, 16'hC020, 2'h0, 16'hC020},
    '{8'hD7, 2'h1, 16'h7000, 2'h0, 16'h0070},
    '{8'hDC, 2'h0, 16'h0000, 2'h2, 16'hB702},
    '{8'hDF, 2'h0, 16'h0000, 2'h2, 16'h5501}
  };

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // watchdog: the whole run needs some 4100 clk
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done();
  end

  initial begin
    sys_rst = 1'b1;
    ce = 1'b1;
    irq_events = 8'h00;
    adc_data = {10'h155, 10'h000, 10'h000, 10'h2B7};
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    // reset image
    chk({14'h0000, reply_oe_n, irq_oe_n}, 16'h0003);
    chk({13'h0000, dac_wide_select}, 16'h0000);
    chk(look(SCP_CMD_DACCTL), 16'h0000);
    for (int i = 0; i < 11; i++) begin
      xact(rows[i].c, rows[i].nw, rows[i].wd, rows[i].nr, rd);
      chk((rows[i].nr != 0) ? rd : look(rows[i].c), rows[i].ex);
    end
    chk({10'h000, dac_wide_select, dac_drive_en}, 16'h0017);
    // divider ratio 4: ten ticks in forty clk
    ticks = 0;
    repeat (40) begin
      @(posedge clk);
      #1 ticks += adc_tick;
    end
    chk(ticks[15:0], 16'h000A);
    // reset command clears config and codes but keeps levels
    xact(SCP_CMD_RESET, 0, 16'h0000, 0, rd);
    chk(look(SCP_CMD_DACCTL), 16'h0000);
    chk(look(8'hD5), 16'h0000);
    chk(look(SCP_CMD_LEVEL1), 16'h8010);
    // select released mid-byte drops the partial byte
    host.sel(1'b0);
    host.shift(SCP_CMD_DAC1, 8, rd[7:0]);
    host.shift(8'h77, 5, rd[7:0]);
    host.sel(1'b1);
    chk(look(SCP_CMD_DAC1), 16'h0000);
    // wide dac given one byte only: nothing latched
    xact(SCP_CMD_DACCTL, 1, 16'h8000, 0, rd);
    xact(SCP_CMD_DAC1, 1, 16'h6600, 0, rd);
    chk(look(SCP_CMD_DAC1), 16'h0000);
    // narrow dac ignores a second byte
    xact(8'hD5, 2, 16'h3CC3, 0, rd);
    chk(look(8'hD5), 16'h003C);
    // unknown command changes nothing
    xact(8'h55, 1, 16'h9900, 0, rd);
    chk(look(SCP_CMD_DACCTL), 16'h0080);
    // disabled condition is recorded but leaves the pin released
    pulse(8'h04);
    chk({15'h0000, irq_oe_n}, 16'h0001);
    xact(SCP_CMD_IRQRD, 0, 16'h0000, 1, rd);
    chk(rd, 16'h0400);
    // enabled condition pulls the pin low until the flags are read
    pulse(8'h02);
    chk({14'h0000, irq_oe_n, irq_data}, 16'h0000);
    xact(SCP_CMD_IRQRD, 0, 16'h0000, 1, rd);
    chk(rd, 16'h0200);
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0000, irq_oe_n}, 16'h0001);
    // low clock enable freezes the port, so the event is never recorded
    ce = 1'b0;
    pulse(8'h01);
    ce = 1'b1;
    chk({15'h0000, irq_oe_n}, 16'h0001);
    xact(SCP_CMD_IRQRD, 0, 16'h0000, 1, rd);
    chk(rd, 16'h0000);
    test_done();
  end
endmodule : tb_top
